// ### hw/bdm_core.v
`include "bdm_defines.vh"

// Notes on behaviour
// - adding accumulator to pc low jumps within the page, low byte wraps
// - table transfers move one byte via latch
// - every data location has 12-bit address
// - sixteen 256-byte banks, low four select bits
// - unimplemented locations always read as zero
// - special registers top half bank 15
// - general storage never cleared by reset
// - pointers hold 12 bits, ignore bank select
// - file move takes two cycles, any bank
// - access region reachable without bank select
// - indirect operands have no own storage
// - pc low write loads, read copies upper
// - read in second quarter, write fourth
module bdm_core (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        op_start,
  input  wire [2:0]  op_code,
  input  wire        op_abit,
  input  wire [7:0]  op_faddr,
  input  wire [11:0] op_src,
  input  wire [11:0] op_dst,
  input  wire [7:0]  op_wdata,
  input  wire        pc_step,
  input  wire        pc_jump,
  input  wire [20:0] pc_target,
  input  wire [7:0]  tbl_rd_data,
  output reg  [1:0]  q_phase_reg,
  output reg  [7:0]  rd_data_reg,
  output reg         rd_valid_reg,
  output reg         busy_reg,
  output reg  [20:0] pc_reg,
  output wire [21:0] tbl_addr,
  output reg         tbl_rd_req_reg,
  output reg         tbl_wr_req_reg,
  output reg  [7:0]  tbl_wr_data_reg
);

  // ************************************************************
  // storage
  // ************************************************************
  reg  [7:0]  gpr_mem [0:4095];
  reg  [3:0]  bank_reg;
  reg  [7:0]  acc_reg;
  reg  [7:0]  tlat_reg;
  reg  [7:0]  tlow_reg;
  reg  [7:0]  thigh_reg;
  reg  [5:0]  tup_reg;
  reg  [7:0]  hold_hi_reg;
  reg  [4:0]  hold_up_reg;
  reg  [2:0]  cur_op_reg;
  reg         cur_abit_reg;
  reg  [7:0]  cur_faddr_reg;
  reg  [11:0] cur_src_reg;
  reg  [11:0] cur_dst_reg;
  reg  [7:0]  cur_wdata_reg;
  reg         move2_reg;
  reg  [11:0] eff_reg;
  reg         eff_ind_reg;
  reg         pupd_en_reg;
  reg         pupd_sel_reg;
  reg  [11:0] pupd_val_reg;
  wire [23:0] ptr_bus;

  // ************************************************************
  // indirect operand decode: {hit, pointer, kind}
  // ************************************************************
  function [4:0] ind_dec;
    input [11:0] a;
    reg   [11:0] d0;
    reg   [11:0] d1;
    begin
      d0 = `BDM_OFS_INDIRECT0 - a;
      d1 = `BDM_OFS_INDIRECT1 - a;
      if (d0 <= `BDM_INDIRECT_SPAN) begin
        ind_dec = {1'b1, 1'b0, d0[2:0]};
      end else if (d1 <= `BDM_INDIRECT_SPAN) begin
        ind_dec = {1'b1, 1'b1, d1[2:0]};
      end else begin
        ind_dec = 5'h00;
      end
    end
  endfunction

  // ************************************************************
  // address resolution during the second quarter
  // ************************************************************
  reg  [11:0] log_addr;
  reg  [4:0]  dec;
  reg  [11:0] sel_ptr;
  reg  [11:0] phys_addr;
  reg         ptr_mod;
  reg  [11:0] ptr_new;

  // logical then physical address
  always @* begin
    if (cur_op_reg == `BDM_OP_MOVE) begin
      log_addr = move2_reg ? cur_dst_reg : cur_src_reg;
    end else if (cur_abit_reg) begin
      log_addr = {bank_reg, cur_faddr_reg};
    end else if (cur_faddr_reg < `BDM_ACCESS_SPLIT) begin
      log_addr = {`BDM_ACCESS_LOW_BANK, cur_faddr_reg};
    end else begin
      log_addr = {`BDM_ACCESS_HIGH_BANK, cur_faddr_reg};
    end
    dec = ind_dec(log_addr);
    sel_ptr = dec[3] ? ptr_bus[23:12] : ptr_bus[11:0];
    phys_addr = log_addr;
    ptr_mod = 1'b0;
    ptr_new = sel_ptr;
    if (dec[4]) begin
      // pointer substitutes for the operand address
      ptr_mod = dec[2:0] != `BDM_IND_PLAIN &&
                dec[2:0] != `BDM_IND_PLUS_ACC;
      ptr_new = (dec[2:0] == `BDM_IND_POST_DEC) ? sel_ptr - 12'h001 :
                                                  sel_ptr + 12'h001;
      phys_addr = sel_ptr;
      if (dec[2:0] == `BDM_IND_PRE_INC) begin
        phys_addr = ptr_new;
      end else if (dec[2:0] == `BDM_IND_PLUS_ACC) begin
        phys_addr = sel_ptr + {{4{acc_reg[7]}}, acc_reg};
      end
    end
  end

  // ************************************************************
  // read multiplexer
  // ************************************************************
  reg  [7:0]  rd_val;
  wire        phys_ind = ind_dec(phys_addr) != 5'h00;

  // unmapped and nested indirect reads give zero
  always @* begin
    case (phys_addr)
      `BDM_OFS_BANK_SELECT:   rd_val = {4'h0, bank_reg};
      `BDM_OFS_PTR1_LOW:      rd_val = ptr_bus[19:12];
      `BDM_OFS_PTR1_HIGH:     rd_val = {4'h0, ptr_bus[23:20]};
      `BDM_OFS_ACCUMULATOR:   rd_val = acc_reg;
      `BDM_OFS_PTR0_LOW:      rd_val = ptr_bus[7:0];
      `BDM_OFS_PTR0_HIGH:     rd_val = {4'h0, ptr_bus[11:8]};
      `BDM_OFS_TABLE_LATCH:   rd_val = tlat_reg;
      `BDM_OFS_TABLE_LOW:     rd_val = tlow_reg;
      `BDM_OFS_TABLE_HIGH:    rd_val = thigh_reg;
      `BDM_OFS_TABLE_UPPER:   rd_val = {2'h0, tup_reg};
      `BDM_OFS_PC_LOW:        rd_val = pc_reg[7:0];
      `BDM_OFS_PC_HIGH_HOLD:  rd_val = hold_hi_reg;
      `BDM_OFS_PC_UPPER_HOLD: rd_val = {3'h0, hold_up_reg};
      default: begin
        rd_val = (phys_addr < `BDM_GPR_END) ? gpr_mem[phys_addr] :
                 `BDM_RST_BYTE;
      end
    endcase
  end

  // ************************************************************
  // fourth-quarter write decode
  // ************************************************************
  wire        in_q4 = q_phase_reg == `BDM_Q4;
  wire        wr_op = (cur_op_reg == `BDM_OP_WRITE) ||
                      (cur_op_reg == `BDM_OP_ADD_ACC) ||
                      ((cur_op_reg == `BDM_OP_MOVE) && move2_reg);
  wire        wr_en = in_q4 && wr_op && !eff_ind_reg;
  wire [7:0]  wr_sum = rd_data_reg + acc_reg;
  wire [7:0]  wr_data = (cur_op_reg == `BDM_OP_WRITE) ? cur_wdata_reg :
                        (cur_op_reg == `BDM_OP_ADD_ACC) ? wr_sum :
                        rd_data_reg;
  wire        rd_op = (cur_op_reg == `BDM_OP_READ) ||
                      (cur_op_reg == `BDM_OP_ADD_ACC) ||
                      ((cur_op_reg == `BDM_OP_MOVE) && !move2_reg);

  assign tbl_addr = {tup_reg, thigh_reg, tlow_reg};

  // ************************************************************
  // quarter sequencer and request capture
  // ************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_phase_reg <= `BDM_Q1;
      cur_op_reg <= `BDM_OP_NOP;
      cur_abit_reg <= 1'b0;
      cur_faddr_reg <= `BDM_RST_BYTE;
      cur_src_reg <= `BDM_RST_PTR;
      cur_dst_reg <= `BDM_RST_PTR;
      cur_wdata_reg <= `BDM_RST_BYTE;
      move2_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      q_phase_reg <= q_phase_reg + 2'h1;
      // new request only in first quarter when not mid-move
      if (q_phase_reg == `BDM_Q1 && !busy_reg) begin
        cur_op_reg <= op_start ? op_code : `BDM_OP_NOP;
        cur_abit_reg <= op_abit;
        cur_faddr_reg <= op_faddr;
        cur_src_reg <= op_src;
        cur_dst_reg <= op_dst;
        cur_wdata_reg <= op_wdata;
      end
      // second word of the file move
      if (in_q4 && cur_op_reg == `BDM_OP_MOVE) begin
        move2_reg <= !move2_reg;
        busy_reg <= !move2_reg;
      end
    end
  end

  // ************************************************************
  // second-quarter read capture and table strobes
  // ************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= `BDM_RST_BYTE;
      rd_valid_reg <= 1'b0;
      eff_reg <= `BDM_RST_PTR;
      eff_ind_reg <= 1'b0;
      pupd_en_reg <= 1'b0;
      pupd_sel_reg <= 1'b0;
      pupd_val_reg <= `BDM_RST_PTR;
      tbl_rd_req_reg <= 1'b0;
      tbl_wr_req_reg <= 1'b0;
      tbl_wr_data_reg <= `BDM_RST_BYTE;
    end else begin
      rd_valid_reg <= 1'b0;
      tbl_rd_req_reg <= 1'b0;
      tbl_wr_req_reg <= 1'b0;
      if (q_phase_reg == `BDM_Q2) begin
        eff_reg <= phys_addr;
        eff_ind_reg <= phys_ind;
        pupd_en_reg <= ptr_mod && cur_op_reg != `BDM_OP_NOP &&
                       cur_op_reg != `BDM_OP_TABLE_READ &&
                       cur_op_reg != `BDM_OP_TABLE_WRITE;
        pupd_sel_reg <= dec[3];
        pupd_val_reg <= ptr_new;
        if (rd_op) begin
          rd_data_reg <= rd_val;
          rd_valid_reg <= 1'b1;
        end
        // one byte per table transfer
        tbl_rd_req_reg <= cur_op_reg == `BDM_OP_TABLE_READ;
        tbl_wr_req_reg <= cur_op_reg == `BDM_OP_TABLE_WRITE;
        tbl_wr_data_reg <= tlat_reg;
      end else if (in_q4) begin
        pupd_en_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // file pointers, explicit write beats auto update
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ptr
      localparam [11:0] LO = (gi == 0) ? `BDM_OFS_PTR0_LOW :
                                         `BDM_OFS_PTR1_LOW;
      localparam [11:0] HI = (gi == 0) ? `BDM_OFS_PTR0_HIGH :
                                         `BDM_OFS_PTR1_HIGH;
      reg [11:0] value_reg;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          value_reg <= `BDM_RST_PTR;
        end else if (wr_en && eff_reg == LO) begin
          value_reg <= {value_reg[11:8], wr_data};
        end else if (wr_en && eff_reg == HI) begin
          value_reg <= {wr_data[3:0], value_reg[7:0]};
        end else if (in_q4 && pupd_en_reg && pupd_sel_reg == (gi != 0)) begin
          value_reg <= pupd_val_reg;
        end
      end
      assign ptr_bus[12*gi +: 12] = value_reg;
    end
  endgenerate

  // ************************************************************
  // core special registers and program counter
  // ************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_reg <= 4'h0;
      acc_reg <= `BDM_RST_BYTE;
      tlat_reg <= `BDM_RST_BYTE;
      tlow_reg <= `BDM_RST_BYTE;
      thigh_reg <= `BDM_RST_BYTE;
      tup_reg <= 6'h00;
      hold_hi_reg <= `BDM_RST_BYTE;
      hold_up_reg <= 5'h00;
      pc_reg <= `BDM_RST_PC;
    end else begin
      // reading pc low snapshots the upper bits
      if (q_phase_reg == `BDM_Q2 && rd_op &&
          phys_addr == `BDM_OFS_PC_LOW) begin
        hold_hi_reg <= pc_reg[15:8];
        hold_up_reg <= pc_reg[20:16];
      end
      if (q_phase_reg == `BDM_Q1 && pc_jump) begin
        pc_reg <= {pc_target[20:1], 1'b0};
      end else if (q_phase_reg == `BDM_Q1 && pc_step) begin
        pc_reg <= pc_reg + 21'h000002;
      end
      if (in_q4 && cur_op_reg == `BDM_OP_TABLE_READ) begin
        tlat_reg <= tbl_rd_data;
      end
      if (wr_en) begin
        case (eff_reg)
          `BDM_OFS_BANK_SELECT:   bank_reg <= wr_data[3:0];
          `BDM_OFS_ACCUMULATOR:   acc_reg <= wr_data;
          `BDM_OFS_TABLE_LATCH:   tlat_reg <= wr_data;
          `BDM_OFS_TABLE_LOW:     tlow_reg <= wr_data;
          `BDM_OFS_TABLE_HIGH:    thigh_reg <= wr_data;
          `BDM_OFS_TABLE_UPPER:   tup_reg <= wr_data[5:0];
          `BDM_OFS_PC_HIGH_HOLD:  hold_hi_reg <= wr_data;
          `BDM_OFS_PC_UPPER_HOLD: hold_up_reg <= wr_data[4:0];
          `BDM_OFS_PC_LOW: // computed jump lands here
            pc_reg <= {hold_up_reg, hold_hi_reg, wr_data[7:1], 1'b0};
          default: bank_reg <= bank_reg;
        endcase
      end
    end
  end

  // ************************************************************
  // general storage, no reset on purpose
  // ************************************************************
  always @(posedge clk) begin
    if (wr_en && eff_reg < `BDM_GPR_END) begin
      gpr_mem[eff_reg] <= wr_data;
    end
  end

endmodule

// ### hw/bdm_defines.vh
`ifndef BDM_DEFINES_VH
`define BDM_DEFINES_VH

// ************************************************************
// core register offsets in the 12-bit data space
// ************************************************************
`define BDM_OFS_BANK_SELECT     12'hfe0
`define BDM_OFS_PTR1_LOW        12'hfe1
`define BDM_OFS_PTR1_HIGH       12'hfe2
`define BDM_OFS_INDIRECT1       12'hfe7
`define BDM_OFS_ACCUMULATOR     12'hfe8
`define BDM_OFS_PTR0_LOW        12'hfe9
`define BDM_OFS_PTR0_HIGH       12'hfea
`define BDM_OFS_INDIRECT0       12'hfef
`define BDM_OFS_TABLE_LATCH     12'hff5
`define BDM_OFS_TABLE_LOW       12'hff6
`define BDM_OFS_TABLE_HIGH      12'hff7
`define BDM_OFS_TABLE_UPPER     12'hff8
`define BDM_OFS_PC_LOW          12'hff9
`define BDM_OFS_PC_HIGH_HOLD    12'hffa
`define BDM_OFS_PC_UPPER_HOLD   12'hffb

// ************************************************************
// memory map layout
// ************************************************************
`define BDM_GPR_END             12'h600
`define BDM_ACCESS_SPLIT        8'h80
`define BDM_ACCESS_LOW_BANK     4'h0
`define BDM_ACCESS_HIGH_BANK    4'hf
`define BDM_INDIRECT_SPAN       12'h004

// ************************************************************
// reset values
// ************************************************************
`define BDM_RST_BYTE            8'h00
`define BDM_RST_PTR             12'h000
`define BDM_RST_PC              21'h000000

// ************************************************************
// indirect access kinds (offset below the plain operand)
// ************************************************************
`define BDM_IND_PLAIN           3'h0
`define BDM_IND_POST_INC        3'h1
`define BDM_IND_POST_DEC        3'h2
`define BDM_IND_PRE_INC         3'h3
`define BDM_IND_PLUS_ACC        3'h4

// ************************************************************
// operations and quarters
// ************************************************************
`define BDM_OP_NOP              3'h0
`define BDM_OP_READ             3'h1
`define BDM_OP_WRITE            3'h2
`define BDM_OP_ADD_ACC          3'h3
`define BDM_OP_MOVE             3'h4
`define BDM_OP_TABLE_READ       3'h5
`define BDM_OP_TABLE_WRITE      3'h6
`define BDM_Q1                  2'h0
`define BDM_Q2                  2'h1
`define BDM_Q3                  2'h2
`define BDM_Q4                  2'h3

`endif

// ### verif/bdm_core_properties.sv
// ****************************************************
// port checker for the banked data memory core
// ****************************************************
module bdm_core_properties (
  input wire        clk,
  input wire        rst_n,
  input wire        op_start,
  input wire [2:0]  op_code,
  input wire        op_abit,
  input wire [7:0]  op_faddr,
  input wire [11:0] op_src,
  input wire [11:0] op_dst,
  input wire [7:0]  op_wdata,
  input wire        pc_step,
  input wire        pc_jump,
  input wire [20:0] pc_target,
  input wire [7:0]  tbl_rd_data,
  input wire [1:0]  q_phase_reg,
  input wire [7:0]  rd_data_reg,
  input wire        rd_valid_reg,
  input wire        busy_reg,
  input wire [20:0] pc_reg,
  input wire [21:0] tbl_addr,
  input wire        tbl_rd_req_reg,
  input wire        tbl_wr_req_reg,
  input wire [7:0]  tbl_wr_data_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  // request taken at the edge ending q1
  wire take = q_phase_reg == 2'h0 && !busy_reg && op_start;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  phase_step_a: assert property (1 |=>
    q_phase_reg == $past(q_phase_reg) + 2'h1) else $error("quarter skip");
  read_answer_a: assert property (take && op_code == 3'h1 |->
    ##2 rd_valid_reg ##1 !rd_valid_reg) else $error("read answer late");
  valid_q3_a: assert property (rd_valid_reg |-> q_phase_reg == 2'h2)
    else $error("read valid outside q3");
  move_busy_a: assert property (take && op_code == 3'h4 |->
    ##4 busy_reg [*4] ##1 !busy_reg) else $error("move length wrong");
  move_quiet_a: assert property (busy_reg |-> !rd_valid_reg)
    else $error("read valid in move cycle two");
  tbl_read_a: assert property (take && op_code == 3'h5 |->
    ##2 tbl_rd_req_reg ##1 !tbl_rd_req_reg) else $error("table read req");
  tbl_write_a: assert property (take && op_code == 3'h6 |->
    ##2 (tbl_wr_req_reg && q_phase_reg == 2'h2) ##1 !tbl_wr_req_reg)
    else $error("table write req");
  pc_align_a: assert property (!pc_reg[0])
    else $error("pc odd");
  pc_jump_a: assert property (q_phase_reg == 2'h0 && pc_jump |=>
    (pc_reg >> 1) == ($past(pc_target) >> 1)) else $error("pc jump");
  pc_step_a: assert property (pc_step && !pc_jump &&
    q_phase_reg == 2'h0 |=> pc_reg == $past(pc_reg) + 21'h2)
    else $error("pc step");
  c_read: cover property (take && op_code == 3'h1 ##2 rd_valid_reg);
  c_move: cover property (take && op_code == 3'h4 ##4 busy_reg);
  c_table: cover property (take && op_code == 3'h5 ##2 tbl_rd_req_reg);
endmodule

// ### verif/bdm_prog_mem.sv
// ****************************************************
// program memory model answering table reads
// ****************************************************
module bdm_prog_mem (
  input  wire        clk,
  input  wire [21:0] tbl_addr,
  input  wire        tbl_rd_req_reg,
  output logic [7:0] tbl_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // byte valid in q4 only, toggles otherwise
  initial tbl_rd_data = 8'h00;
  always @(posedge clk) begin
    if (tbl_rd_req_reg)
      tbl_rd_data <= tbl_addr[0] ? tbl_addr[15:8] : tbl_addr[7:0] ^ 8'h5a;
    else
      tbl_rd_data <= ~tbl_rd_data;
  end
endmodule

// ### verif/banked_data_memory_map_tb.sv
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  mismatches++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module banked_data_memory_map_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, op_start = 0, op_abit = 0;
  logic        pc_step = 0, pc_jump = 0;
  logic [2:0]  op_code = 0;
  logic [7:0]  op_faddr = 0, op_wdata = 0, rdv, twd;
  logic [11:0] op_src = 0, op_dst = 0;
  logic [20:0] pc_target = 0;
  wire  [7:0]  tbl_rd_data, rd_data_reg, tbl_wr_data_reg;
  wire  [1:0]  q_phase_reg;
  wire         rd_valid_reg, busy_reg, tbl_rd_req_reg, tbl_wr_req_reg;
  wire  [20:0] pc_reg;
  wire  [21:0] tbl_addr;
  int          mismatches = 0, samples_checked = 0;
  always #4 clk = ~clk;
  bdm_core bdm_core_inst (.clk(clk), .rst_n(rst_n), .op_start(op_start),
    .op_code(op_code), .op_abit(op_abit), .op_faddr(op_faddr),
    .op_src(op_src), .op_dst(op_dst), .op_wdata(op_wdata),
    .pc_step(pc_step), .pc_jump(pc_jump), .pc_target(pc_target),
    .tbl_rd_data(tbl_rd_data), .q_phase_reg(q_phase_reg),
    .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
    .busy_reg(busy_reg), .pc_reg(pc_reg), .tbl_addr(tbl_addr),
    .tbl_rd_req_reg(tbl_rd_req_reg), .tbl_wr_req_reg(tbl_wr_req_reg),
    .tbl_wr_data_reg(tbl_wr_data_reg));
  bdm_prog_mem bdm_prog_mem_inst (.clk(clk), .tbl_addr(tbl_addr),
    .tbl_rd_req_reg(tbl_rd_req_reg), .tbl_rd_data(tbl_rd_data));
  // ****************************************************
  // run control
  // ****************************************************
  task stop_test;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // wait for q1 with the core free
  task wait_q1;
    int i;
    i = 0;
    while (!(q_phase_reg === 2'h0 && busy_reg === 1'b0)) begin
      @(posedge clk);
      #1;
      i++;
      if (i > 20) begin
        mismatches++;
        $display("[ERR] wait_q1 timeout");
        stop_test;
      end
    end
  endtask
  // one instruction cycle on the execution port
  task op(input [2:0] c, input a, input [7:0] f, input [7:0] d);
    wait_q1;
    op_code = c;
    op_abit = a;
    op_faddr = f;
    op_wdata = d;
    op_start = 1;
    @(posedge clk);
    #1 op_start = 0;
    @(posedge clk);
    #1;
    if (rd_valid_reg === 1'b1) rdv = rd_data_reg;
    if (tbl_wr_req_reg === 1'b1) twd = tbl_wr_data_reg;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task wa(input [7:0] f, input [7:0] d);
    op(3'h2, 0, f, d);
  endtask
  task ra(input [7:0] f);
    rdv = 8'hxx;
    op(3'h1, 0, f, 8'h00);
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task t_bank;
    wa(8'he0, 8'hf3);
    ra(8'he0);
    `CHK("bank_select", 8'h03, rdv)
    op(3'h2, 1, 8'h10, 8'ha5);
    wa(8'hea, 8'h03);
    wa(8'he9, 8'h10);
    ra(8'hef);
    `CHK("banked via pointer", 8'ha5, rdv)
    // access region write ignores bank 3, read back through bank 0
    wa(8'h20, 8'h3c);
    wa(8'he0, 8'h00);
    rdv = 8'hxx;
    op(3'h1, 1, 8'h20, 8'h00);
    `CHK("access low", 8'h3c, rdv)
    $display("t_bank done");
  endtask
  task t_unimpl;
    wa(8'he0, 8'h07);
    rdv = 8'hxx;
    op(3'h1, 1, 8'h00, 8'h00);
    `CHK("bank 7", 8'h00, rdv)
    ra(8'hff);
    `CHK("top special", 8'h00, rdv)
    wa(8'h80, 8'h77);
    ra(8'h80);
    `CHK("empty special", 8'h00, rdv)
    $display("t_unimpl done");
  endtask
  task t_indirect;
    wa(8'hea, 8'h01);
    wa(8'he9, 8'h00);
    wa(8'hee, 8'h11);
    wa(8'hee, 8'h22);
    ra(8'he9);
    `CHK("post inc ptr", 8'h02, rdv)
    wa(8'he9, 8'h00);
    wa(8'he8, 8'h01);
    ra(8'heb);
    `CHK("plus acc", 8'h22, rdv)
    ra(8'hec);
    `CHK("pre inc", 8'h22, rdv)
    ra(8'hed);
    `CHK("post dec", 8'h22, rdv)
    ra(8'hef);
    `CHK("plain", 8'h11, rdv)
    $display("t_indirect done");
  endtask
  task t_move;
    op_src = 12'h310;
    op_dst = 12'h5ff;
    op(3'h4, 0, 8'h00, 8'h00);
    wa(8'he2, 8'h05);
    wa(8'he1, 8'hff);
    ra(8'he7);
    `CHK("moved byte", 8'ha5, rdv)
    $display("t_move done");
  endtask
  task t_pc;
    wait_q1;
    pc_jump = 1;
    pc_target = 21'h012341;
    @(posedge clk);
    #1 pc_jump = 0;
    `CHK("pc jump", 21'h012340, pc_reg)
    ra(8'hf9);
    `CHK("pc low", 8'h40, rdv)
    ra(8'hfa);
    `CHK("high hold", 8'h23, rdv)
    ra(8'hfb);
    `CHK("upper hold", 8'h01, rdv)
    wa(8'he8, 8'h06);
    op(3'h3, 0, 8'hf9, 8'h00);
    `CHK("computed", 21'h012346, pc_reg)
    wait_q1;
    pc_step = 1;
    @(posedge clk);
    #1 pc_step = 0;
    `CHK("pc step", 21'h012348, pc_reg)
    $display("t_pc done");
  endtask
  task t_table;
    wa(8'hf6, 8'h34);
    wa(8'hf7, 8'h12);
    wa(8'hf8, 8'hc1);
    `CHK("table address", 22'h011234, tbl_addr)
    op(3'h5, 0, 8'h00, 8'h00);
    ra(8'hf5);
    `CHK("table latch", 8'h6e, rdv)
    wa(8'hf5, 8'h9c);
    twd = 8'hxx;
    op(3'h6, 0, 8'h00, 8'h00);
    `CHK("table write", 8'h9c, twd)
    $display("t_table done");
  endtask
  task t_retain;
    wa(8'he0, 8'h02);
    op(3'h2, 1, 8'h00, 8'h5a);
    rst_n = 0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    ra(8'he0);
    `CHK("bank after reset", 8'h00, rdv)
    wa(8'he0, 8'h02);
    rdv = 8'hxx;
    op(3'h1, 1, 8'h00, 8'h00);
    `CHK("kept byte", 8'h5a, rdv)
    $display("t_retain done");
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1;
    t_bank;
    t_unimpl;
    t_indirect;
    t_move;
    t_pc;
    t_table;
    t_retain;
    stop_test;
  end
  // watchdog
  initial begin
    #40000;
    mismatches++;
    $display("[ERR] watchdog");
    stop_test;
  end
endmodule
bind bdm_core bdm_core_properties bdm_core_properties_inst (.clk(clk),
  .rst_n(rst_n), .op_start(op_start), .op_code(op_code),
  .op_abit(op_abit), .op_faddr(op_faddr), .op_src(op_src),
  .op_dst(op_dst), .op_wdata(op_wdata), .pc_step(pc_step),
  .pc_jump(pc_jump), .pc_target(pc_target), .tbl_rd_data(tbl_rd_data),
  .q_phase_reg(q_phase_reg), .rd_data_reg(rd_data_reg),
  .rd_valid_reg(rd_valid_reg), .busy_reg(busy_reg), .pc_reg(pc_reg),
  .tbl_addr(tbl_addr), .tbl_rd_req_reg(tbl_rd_req_reg),
  .tbl_wr_req_reg(tbl_wr_req_reg), .tbl_wr_data_reg(tbl_wr_data_reg));
